// [shared/irw_pkg.sv]
// Purpose: Constants and types shared by the initial reset and watchdog block.
// Assumes: ref_clk_i runs at 10 MHz; the main clock ticks at 32.768 kHz as an enable.
// Notes: Register offsets are word indices on the plain register port.
package irw_pkg;
    localparam int unsigned CLK_HZ = 10000000;
    localparam int unsigned MAIN_CLK_HZ = 32768;
    localparam int unsigned MAIN_DIV_NUM = 32768;
    localparam int unsigned MAIN_DIV_DEN = 10000000;
    // Pin low filter: 2 ms at the main clock, least time rounded up.
    localparam int unsigned PIN_FILTER_US = 2000;
    localparam int unsigned PIN_FILTER_TICKS = (PIN_FILTER_US * 32768 + 999999) / 1000000;
    // Key combination: 2 s at the main clock.
    localparam int unsigned KEY_HOLD_S = 2;
    localparam int unsigned KEY_HOLD_TICKS = KEY_HOLD_S * MAIN_CLK_HZ;
    // Watchdog counts 1 Hz ticks; reset when the count reaches this value.
    localparam int unsigned WDOG_LIMIT = 4;
    localparam logic [2:0] WDOG_LIMIT_W = 3'h4;
    // Main clock ticks per 1 Hz tick.
    localparam int unsigned SEC_TICKS = MAIN_CLK_HZ;
    localparam logic [11:0] ADDR_WDOG_CLR = 12'hF76;
    localparam logic [11:0] ADDR_OSC_CTRL = 12'hF70;
    localparam int WDOG_CLR_BIT = 0;
    localparam int TMR_CLR_BIT = 1;
    localparam int FAST_EN_BIT = 2;
    localparam int CLK_SEL_BIT = 3;
    localparam logic [7:0] PC_STEP_RST = 8'h00;
    localparam logic [3:0] PC_PAGE_RST = 4'h1;
    localparam logic [3:0] NPP_RST = 4'h1;
    localparam logic RST_BIT_ZERO = 1'b0;
    typedef enum logic [1:0] {KEY_OFF, KEY_01, KEY_012, KEY_0123} irw_key_mode_t;
    typedef struct packed {
        logic [7:0] pc_step;
        logic [3:0] pc_page;
        logic pc_bank;
        logic [3:0] next_page_pointer;
        logic next_bank_pointer;
        logic int_flag;
        logic dec_flag;
    } irw_cpu_init_t;
    typedef struct packed {
        logic pin;
        logic key;
        logic osc;
        logic wdog;
    } irw_src_t;
    localparam irw_cpu_init_t CPU_INIT = '{PC_STEP_RST, PC_PAGE_RST, 1'b0, NPP_RST,
        1'b0, 1'b0, 1'b0};
endpackage

// [core/irw_tick_gen.sv]
// Purpose: Fractional divider making the 32.768 kHz main tick and the 1 Hz tick.
// Assumes: One clock; outputs are one-cycle enables.
// Notes: The 1 Hz tick is the clock timer, which software may clear.
`timescale 1ns/10ps
module irw_tick_gen import irw_pkg::*; (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic timer_clear_i,
    output logic main_tick_o,
    output logic sec_tick_o
);
    logic [23:0] acc_r, acc_nxt;
    logic [15:0] sec_r, sec_nxt;
    logic main_r, main_nxt, sec_tick_r, sec_tick_nxt;
    logic [24:0] sum;
    always_comb begin
        sum = {1'b0, acc_r} + 25'(MAIN_DIV_NUM);
        main_nxt = 1'b0;
        acc_nxt = sum[23:0];
        if (sum >= 25'(MAIN_DIV_DEN)) begin
            acc_nxt = 24'(sum - 25'(MAIN_DIV_DEN));
            main_nxt = 1'b1;
        end
        sec_nxt = sec_r;
        sec_tick_nxt = 1'b0;
        if (timer_clear_i) begin
            sec_nxt = 16'h0000;
        end else if (main_r) begin
            if (sec_r == 16'(SEC_TICKS - 1)) begin
                sec_nxt = 16'h0000;
                sec_tick_nxt = 1'b1;
            end else begin
                sec_nxt = sec_r + 16'h0001;
            end
        end
    end
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_r <= 24'h000000;
            main_r <= 1'b0;
            sec_r <= 16'h0000;
            sec_tick_r <= 1'b0;
        end else begin
            acc_r <= acc_nxt;
            main_r <= main_nxt;
            sec_r <= sec_nxt;
            sec_tick_r <= sec_tick_nxt;
        end
    end
    assign main_tick_o = main_r;
    assign sec_tick_o = sec_tick_r;
endmodule // irw_tick_gen

// [core/irw_low_filter.sv]
// Purpose: Reports a low level only after it has lasted a set number of main ticks.
// Assumes: Input already synchronised; tick is a one-cycle enable.
// Notes: Any high level restarts the count, so short pulses are ignored.
`timescale 1ns/10ps
module irw_low_filter import irw_pkg::*; #(
    parameter int unsigned HOLD = 66
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic tick_i,
    input wire logic low_i,
    output logic held_o
);
    logic [17:0] cnt_r, cnt_nxt;
    logic held_r, held_nxt;
    always_comb begin
        cnt_nxt = cnt_r;
        held_nxt = held_r;
        if (!low_i) begin
            cnt_nxt = 18'h00000;
            held_nxt = 1'b0;
        end else if (tick_i && !held_r) begin
            if (cnt_r >= 18'(HOLD - 1)) begin
                held_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 18'h00001;
            end
        end
    end
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r <= 18'h00000;
            held_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            held_r <= held_nxt;
        end
    end
    assign held_o = held_r;
endmodule // irw_low_filter

// [core/irw_reset_core.sv]
// Contract
// - Reset held while pin low, released after.
// - Short pin lows rejected; 2 ms needed.
// - Selected keys low 2 s cause reset.
// - Key group chosen at build time.
// - Reset held until slow oscillator runs.
// - Watchdog resets after 3-4 unserviced seconds.
// - Watchdog keeps counting during halt.
// - Writing one clears watchdog; reads zero.
// - Clock timer clear advances watchdog once.
// - Reset loads fixed CPU register values.
// - Slow clock default; fast clock selectable.
// - Software bit stops the fast oscillator.
// Purpose: Initial reset generation, watchdog and oscillator control registers.
// Assumes: Pins are asynchronous to ref_clk_i; the register port is synchronous.
// Notes: The pin noise rejector delays assertion by 2 ms; release waits only for the next main tick.
`timescale 1ns/10ps
module irw_reset_core import irw_pkg::*; #(
    parameter irw_key_mode_t KEY_MODE = KEY_0123
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic reset_pin_n_i,
    input wire logic [3:0] key_input_pins_i,
    input wire logic osc_running_i,
    input wire logic cpu_halt_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic [3:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [3:0] reg_rdata_o,
    output logic cpu_reset_o,
    output irw_cpu_init_t cpu_init_o,
    output logic fast_osc_enable_o,
    output logic fast_clk_sel_o,
    output irw_src_t reset_cause_o
);
    logic [1:0] pin_sync_r;
    logic [3:0] key_sync0_r, key_sync1_r;
    logic [1:0] osc_sync_r;
    logic main_tick, sec_tick;
    logic pin_held, key_held;
    logic key_low;
    logic wd_clr, tmr_clr;
    logic [2:0] wd_cnt_r, wd_cnt_nxt;
    logic wd_fire_r, wd_fire_nxt;
    logic cpu_reset_r, cpu_reset_nxt;
    logic fast_en_r, fast_en_nxt, clk_sel_r, clk_sel_nxt;
    logic [3:0] rdata_r, rdata_nxt;
    irw_src_t cause_r, cause_nxt;
    irw_src_t req;

    // Two-flop synchronisers for every pin.
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_sync_r <= 2'h0;
            key_sync0_r <= 4'hF;
            key_sync1_r <= 4'hF;
            osc_sync_r <= 2'h0;
        end else begin
            pin_sync_r <= {pin_sync_r[0], reset_pin_n_i};
            key_sync0_r <= key_input_pins_i;
            key_sync1_r <= key_sync0_r;
            osc_sync_r <= {osc_sync_r[0], osc_running_i};
        end
    end

    assign wd_clr = reg_wr_i && (reg_addr_i == ADDR_WDOG_CLR) && reg_wdata_i[WDOG_CLR_BIT];
    assign tmr_clr = reg_wr_i && (reg_addr_i == ADDR_WDOG_CLR) && reg_wdata_i[TMR_CLR_BIT];

    irw_tick_gen u_tick (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .timer_clear_i(tmr_clr),
        .main_tick_o(main_tick),
        .sec_tick_o(sec_tick)
    );

    irw_low_filter #(.HOLD(PIN_FILTER_TICKS)) u_pin_filt (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .tick_i(main_tick),
        .low_i(!pin_sync_r[1]),
        .held_o(pin_held)
    );

    // The key group is fixed at build time; the disabled option never matches.
    always_comb begin
        case (KEY_MODE)
            KEY_01: key_low = ~|key_sync1_r[1:0];
            KEY_012: key_low = ~|key_sync1_r[2:0];
            KEY_0123: key_low = ~|key_sync1_r;
            default: key_low = 1'b0;
        endcase
    end

    irw_low_filter #(.HOLD(KEY_HOLD_TICKS)) u_key_filt (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .tick_i(main_tick),
        .low_i(key_low),
        .held_o(key_held)
    );

    // Watchdog: counts seconds regardless of cpu_halt_i, so halt gives no shelter.
    always_comb begin
        wd_cnt_nxt = wd_cnt_r;
        // The request stands until a main tick, so a watchdog reset lasts a full main period
        // even when a clock timer clear fires it just before a tick.
        wd_fire_nxt = wd_fire_r && !main_tick;
        if (wd_clr) begin
            wd_cnt_nxt = 3'h0;
        end else if (sec_tick || tmr_clr) begin
            if (wd_cnt_r == WDOG_LIMIT_W - 3'h1) begin
                wd_cnt_nxt = 3'h0;
                wd_fire_nxt = 1'b1;
            end else begin
                wd_cnt_nxt = wd_cnt_r + 3'h1;
            end
        end
    end

    always_comb begin
        req.pin = pin_held;
        req.key = key_held;
        req.osc = !osc_sync_r[1];
        req.wdog = wd_fire_r;
        cpu_reset_nxt = cpu_reset_r;
        cause_nxt = cause_r;
        if (|req) begin
            cpu_reset_nxt = 1'b1;
            cause_nxt = cause_r | req;
        end else if (main_tick) begin
            cpu_reset_nxt = 1'b0;
        end
        if (reg_rd_i && reg_addr_i == ADDR_OSC_CTRL) begin
            cause_nxt = '0;
            if (|req) begin
                cause_nxt = req;
            end
        end
    end

    // Clock controls return to slow clock and fast oscillator off on any reset.
    always_comb begin
        fast_en_nxt = fast_en_r;
        clk_sel_nxt = clk_sel_r;
        rdata_nxt = 4'h0;
        if (cpu_reset_r) begin
            fast_en_nxt = 1'b0;
            clk_sel_nxt = 1'b0;
        end else if (reg_wr_i && reg_addr_i == ADDR_OSC_CTRL) begin
            fast_en_nxt = reg_wdata_i[FAST_EN_BIT];
            clk_sel_nxt = reg_wdata_i[CLK_SEL_BIT] && fast_en_r;
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                ADDR_WDOG_CLR: rdata_nxt = {4{RST_BIT_ZERO}};
                ADDR_OSC_CTRL: rdata_nxt = {clk_sel_r, fast_en_r, 2'h0};
                default: rdata_nxt = 4'h0;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wd_cnt_r <= 3'h0;
            wd_fire_r <= 1'b0;
            cpu_reset_r <= 1'b1;
            cause_r <= '0;
            fast_en_r <= 1'b0;
            clk_sel_r <= 1'b0;
            rdata_r <= 4'h0;
        end else begin
            wd_cnt_r <= wd_cnt_nxt;
            wd_fire_r <= wd_fire_nxt;
            cpu_reset_r <= cpu_reset_nxt;
            cause_r <= cause_nxt;
            fast_en_r <= fast_en_nxt;
            clk_sel_r <= clk_sel_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign cpu_reset_o = cpu_reset_r;
    assign cpu_init_o = CPU_INIT;
    assign fast_osc_enable_o = fast_en_r;
    assign fast_clk_sel_o = clk_sel_r;
    assign reg_rdata_o = rdata_r;
    assign reset_cause_o = cause_r;
endmodule // irw_reset_core

// [verification/irw_reset_core_checker.sv]
// Purpose: Port-level checks of reset generation and the oscillator controls.
// Assumes: Pins are synchronised by two flops inside the block.
// Notes: Pin checks allow for synchroniser lag, so they cannot catch a slip of one cycle.
`timescale 1ns/10ps
module irw_reset_core_checker import irw_pkg::*; (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic reset_pin_n_i,
    input wire logic osc_running_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic [3:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [3:0] reg_rdata_o,
    input wire logic cpu_reset_o,
    input wire irw_cpu_init_t cpu_init_o,
    input wire logic fast_osc_enable_o,
    input wire logic fast_clk_sel_o,
    input wire irw_src_t reset_cause_o
);
    logic osc_wr;
    logic wd_rd;
    logic wd_en;
    assign osc_wr = reg_wr_i && reg_addr_i == ADDR_OSC_CTRL && !cpu_reset_o;
    assign wd_rd = reg_rd_i && reg_addr_i == ADDR_WDOG_CLR;
    assign wd_en = reg_wdata_i[2];
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    chk_init_values: assert property (cpu_init_o == {8'h00, 4'h1, 1'b0, 4'h1, 3'h0})
        else $error("CPU initial values wrong");
    chk_pin_holds: assert property (!reset_pin_n_i [*4] ##0 cpu_reset_o |=> cpu_reset_o)
        else $error("Reset released while pin low");
    chk_osc_holds: assert property (!osc_running_i [*5] ##0 cpu_reset_o |=> cpu_reset_o)
        else $error("Reset released before oscillator ran");
    chk_release_cause: assert property ($fell(cpu_reset_o) |-> ($past(reset_pin_n_i, 2)
        || $past(reset_pin_n_i, 3)) && $past(osc_running_i, 2))
        else $error("Reset released with a source active");
    chk_reset_length: assert property ($rose(cpu_reset_o) |=> cpu_reset_o [*4])
        else $error("Reset pulse too short");
    chk_pin_cause: assert property ($rose(cpu_reset_o) && !reset_pin_n_i |-> ##[0:2]
        reset_cause_o.pin)
        else $error("Pin cause not recorded");
    chk_clear_reads_zero: assert property ($past(wd_rd) |-> reg_rdata_o == 4'h0)
        else $error("Watchdog clear bit read nonzero");
    chk_sel_needs_en: assert property ($rose(fast_clk_sel_o) |-> $past(fast_osc_enable_o))
        else $error("Fast clock selected while oscillator off");
    chk_enable_write: assert property ($past(osc_wr) && !cpu_reset_o |->
        fast_osc_enable_o == $past(wd_en))
        else $error("Fast oscillator enable not written");
endmodule // irw_reset_core_checker
bind irw_reset_core irw_reset_core_checker chk (.ref_clk_i, .rst_n_i, .reset_pin_n_i,
    .osc_running_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .cpu_reset_o, .cpu_init_o, .fast_osc_enable_o, .fast_clk_sel_o, .reset_cause_o);

// [verification/irw_board_model.sv]
// Purpose: Board side driving the reset pin, key pins and oscillator status.
// Assumes: Callers change levels right after a rising clock edge.
// Notes: Keys have pull-ups, so released keys read high.
`timescale 1ns/10ps
module irw_board_model (
    input wire logic ref_clk_i,
    output logic reset_pin_n_o,
    output logic [3:0] key_input_pins_o,
    output logic osc_running_o
);
    // The pin is low from power-up until the bench has waited over 2 ms.
    initial begin
        reset_pin_n_o = 1'b0;
        key_input_pins_o = 4'hF;
        osc_running_o = 1'b0;
    end
    task automatic set_pin(input logic v);
        reset_pin_n_o <= v;
    endtask
    task automatic set_keys(input logic [3:0] v);
        key_input_pins_o <= v;
    endtask
    task automatic set_osc(input logic v);
        osc_running_o <= v;
    endtask
endmodule // irw_board_model

// [verification/tb_initial_reset_and_watchdog.sv]
// Purpose: Self-checking bench for pin, key, oscillator and register behaviour.
// Assumes: Default key group of all four pins.
// Notes: Key holds of seconds exceed the run length; clock timer clears make the watchdog fire.
`timescale 1ns/10ps
module tb_initial_reset_and_watchdog;
    import irw_pkg::*;
    logic ref_clk_i;
    logic rst_n_i;
    logic pin_n, osc, cpu_halt_i, reg_wr_i, reg_rd_i;
    logic [3:0] keys, reg_wdata_i, reg_rdata_o;
    logic [11:0] reg_addr_i;
    logic cpu_reset_o, fast_osc_enable_o, fast_clk_sel_o;
    irw_cpu_init_t cpu_init_o;
    irw_src_t reset_cause_o;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    irw_board_model board (.ref_clk_i(ref_clk_i), .reset_pin_n_o(pin_n),
        .key_input_pins_o(keys), .osc_running_o(osc));
    irw_reset_core dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reset_pin_n_i(pin_n),
        .key_input_pins_i(keys), .osc_running_i(osc), .cpu_halt_i(cpu_halt_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .cpu_reset_o(cpu_reset_o),
        .cpu_init_o(cpu_init_o), .fast_osc_enable_o(fast_osc_enable_o),
        .fast_clk_sel_o(fast_clk_sel_o), .reset_cause_o(reset_cause_o));
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    task automatic conclude();
        if (miscompares == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    task automatic wr(input logic [11:0] a, input logic [3:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        wait_clk(1);
        reg_wr_i <= 1'b0;
        wait_clk(1);
    endtask
    task automatic rd(input logic [11:0] a, input logic [3:0] exp);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        wait_clk(1);
        reg_rd_i <= 1'b0;
        #1 check(reg_rdata_o, exp);
        wait_clk(1);
    endtask
    task automatic s_power_up();
        wait_clk(25000);
        check(cpu_reset_o, 1'b1);
        check(cpu_init_o, {8'h00, 4'h1, 1'b0, 4'h1, 3'h0});
        board.set_pin(1'b1);
        wr(ADDR_OSC_CTRL, 4'h4);
        wait_clk(4000);
        check({cpu_reset_o, fast_osc_enable_o}, 2'b10);
        board.set_osc(1'b1);
        wait_clk(800);
        check({cpu_reset_o, fast_osc_enable_o, fast_clk_sel_o}, 3'b000);
        check(reset_cause_o, 4'hA);
    endtask
    task automatic s_registers();
        wr(ADDR_OSC_CTRL, 4'h8);
        check(fast_clk_sel_o, 1'b0);
        wr(ADDR_OSC_CTRL, 4'h4);
        check(fast_osc_enable_o, 1'b1);
        wr(ADDR_OSC_CTRL, 4'hC);
        check(fast_clk_sel_o, 1'b1);
        rd(ADDR_OSC_CTRL, 4'hC);
        wr(ADDR_WDOG_CLR, 4'h1);
        rd(ADDR_WDOG_CLR, 4'h0);
        wr(ADDR_WDOG_CLR, 4'h2);
        rd(12'h123, 4'h0);
        check(cpu_reset_o, 1'b0);
    endtask
    task automatic s_mid_reset();
        rst_n_i <= 1'b0;
        wait_clk(3);
        check({cpu_reset_o, fast_osc_enable_o, fast_clk_sel_o, reset_cause_o}, 7'h40);
        rst_n_i <= 1'b1;
        wait_clk(2);
        check(cpu_reset_o, 1'b1);
        wait_clk(400);
        check({cpu_reset_o, reset_cause_o}, 5'h02);
    endtask
    task automatic s_watchdog();
        wr(ADDR_WDOG_CLR, 4'h2);
        wr(ADDR_WDOG_CLR, 4'h2);
        wr(ADDR_WDOG_CLR, 4'h1);
        wr(ADDR_WDOG_CLR, 4'h2);
        wr(ADDR_WDOG_CLR, 4'h2);
        wr(ADDR_WDOG_CLR, 4'h2);
        wait_clk(2);
        check(cpu_reset_o, 1'b0);
        wr(ADDR_WDOG_CLR, 4'h2);
        wait_clk(1);
        check({cpu_reset_o, reset_cause_o.wdog}, 2'b11);
        wait_clk(800);
        check(cpu_reset_o, 1'b0);
    endtask
    task automatic s_short_lows();
        cpu_halt_i <= 1'b1;
        board.set_pin(1'b0);
        wait_clk(15000);
        check(cpu_reset_o, 1'b0);
        board.set_pin(1'b1);
        board.set_keys(4'h0);
        wait_clk(1000);
        check(cpu_reset_o, 1'b0);
        board.set_keys(4'hF);
        cpu_halt_i <= 1'b0;
    endtask
    task automatic s_pin_long();
        board.set_pin(1'b0);
        wait_clk(21500);
        check({cpu_reset_o, reset_cause_o.pin}, 2'b11);
        board.set_pin(1'b1);
        wait_clk(800);
        check({cpu_reset_o, fast_osc_enable_o}, 2'b00);
        rd(ADDR_OSC_CTRL, 4'h0);
        check(reset_cause_o, 4'h0);
    endtask
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 95000) begin
            miscompares++;
            conclude();
        end
    end
    initial begin
        rst_n_i = 1'b0;
        cpu_halt_i = 1'b0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_wdata_i = 4'h0;
        reg_addr_i = 12'h000;
        wait_clk(3);
        rst_n_i <= 1'b1;
        s_power_up();
        s_registers();
        s_mid_reset();
        s_watchdog();
        s_short_lows();
        s_pin_long();
        conclude();
    end
endmodule // tb_initial_reset_and_watchdog
